/* design/urp_top.sv */
// Purpose : Two-pin asynchronous serial port giving a host access to registers.
// Assumes : Register file answers a read one cycle after reg_re_o.
// Notes   : Framing is 8N1 at a 16x sample tick from a fractional divider.
`timescale 1ns/1ps

// Contract
// [RQ1] Serial mode from strap or boot select 10
// [RQ2] Receive and transmit pins only, no handshake
// [RQ3] One start, eight data, one stop, no parity
// [RQ4] Resync on start edge, sample bit centres
// [RQ5] M/N divider makes sixteen-times sample clock
// [RQ6] Numerator holds M, limit holds N minus M
// [RQ7] New divider values apply once port idle
// [RQ8] Reset divider gives 9600 baud: 4, 2021
// [RQ9] Burst address advances after each data byte
// [RQ10] Host sends zero, command, address, length, data
// [RQ11] High address byte ignored, low byte used
// [RQ12] Command bits 5:4: nop, read, write
// [RQ13] Command bit 1 set holds the address
// [RQ14] Command bit 0 requests acknowledge at completion
// [RQ15] Read data first, then acknowledge byte 5A
// [RQ16] Host keeps bursts inside one register page
// [RQ17] Double-address bit clear expects one address byte
// [RQ18] Unused command bits ignored, code 11 nop
// [RQ19] Transmit LSB first, sixteen ticks, idle high
module urp_top
    import urp_pkg::*;
(
    input  wire logic        clock_i,      // System clock
    input  wire logic        rstn_i,       // Synchronous reset, active low
    input  wire logic        ce_i,         // Clock enable, freezes all state when low
    input  wire logic [1:0]  mode_strap_i, // Mode strap pins, asynchronous
    input  wire logic        eep_sel_wr_i, // Boot loader writes interface select
    input  wire logic [1:0]  eep_sel_i,    // Interface select value from boot loader
    input  wire logic [15:0] baud_freq_i,  // Numerator word: M and double-address bit
    input  wire logic [15:0] baud_limit_i, // Limit word: N minus M
    input  wire logic        rx_i,         // Serial receive pin, asynchronous
    output logic             tx_o,         // Serial transmit pin
    output logic [7:0]       reg_addr_o,   // Register address
    output logic [7:0]       reg_wdata_o,  // Register write data
    output logic             reg_we_o,     // Register write strobe
    output logic             reg_re_o,     // Register read strobe
    input  wire logic [7:0]  reg_rdata_i,  // Read data, valid cycle after reg_re_o
    output logic             uart_mode_o,  // Serial host mode selected
    output logic             busy_o,       // Command or character in flight
    output logic             frame_err_o   // Bad stop bit seen, one cycle
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic [1:0] cmd_op(input logic [7:0] c);
        return c[CMD_OP_LSB +: 2]; // [RQ12] [RQ18]
    endfunction

    function automatic urp_proto_st_t finish_st(input logic [7:0] c);
        return c[CMD_ACK_BIT] ? P_ACK : P_ZERO; // [RQ14]
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [2:0] sync_in;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    assign sync_in = {mode_strap_i, rx_i};

    // Two flops per pin; only the second stage is looked at
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clock_i) begin
                if (!rstn_i) begin
                    sync1_reg[gi] <= SYNC_RST[gi];
                    sync2_reg[gi] <= SYNC_RST[gi];
                end else if (ce_i) begin
                    sync1_reg[gi] <= sync_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    logic       rx_s;
    logic [1:0] strap_s;
    assign rx_s    = sync2_reg[0]; // [RQ2]
    assign strap_s = sync2_reg[2:1];

    // ------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------
    logic [1:0] cap_cnt_reg;
    logic [1:0] cap_cnt_next;
    logic       mode_reg;
    logic       mode_next;

    // Strap is taken after the synchroniser has filled; boot loader may override
    always_comb begin
        cap_cnt_next = cap_cnt_reg;
        mode_next    = mode_reg;
        if (cap_cnt_reg != STRAP_WAIT) begin
            cap_cnt_next = cap_cnt_reg + 2'h1;
            mode_next    = (strap_s == MODE_UART); // [RQ1]
        end
        if (eep_sel_wr_i) begin
            mode_next = (eep_sel_i == MODE_UART); // [RQ1]
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            cap_cnt_reg <= 2'h0;
            mode_reg    <= 1'b0;
        end else if (ce_i) begin
            cap_cnt_reg <= cap_cnt_next;
            mode_reg    <= mode_next;
        end
    end

    // ------------------------------------------------------------------
    // Divider configuration, applied only while idle
    // ------------------------------------------------------------------
    logic [7:0]  m_reg;
    logic [7:0]  m_next;
    logic [15:0] lim_reg;
    logic [15:0] lim_next;
    logic        dbl_reg;
    logic        dbl_next;
    logic        idle;
    logic        tick;
    logic        we_reg;
    urp_proto_st_t p_reg;
    urp_rx_st_t    rx_st_reg;
    urp_tx_st_t    tx_st_reg;

    assign idle = (p_reg == P_ZERO) && (rx_st_reg == R_IDLE) && (tx_st_reg == T_IDLE) && !we_reg;

    // Holding old values mid-command keeps a half-written divider from garbling bytes
    always_comb begin
        m_next   = m_reg;
        lim_next = lim_reg;
        dbl_next = dbl_reg;
        if (idle) begin
            m_next   = baud_freq_i[7:0];       // [RQ6] [RQ7]
            lim_next = baud_limit_i;           // [RQ6] [RQ7]
            dbl_next = baud_freq_i[CFG_DBL_BIT]; // [RQ17]
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            m_reg   <= M_RST;     // [RQ8]
            lim_reg <= LIMIT_RST; // [RQ8]
            dbl_reg <= DBL_RST;
        end else if (ce_i) begin
            m_reg   <= m_next;
            lim_reg <= lim_next;
            dbl_reg <= dbl_next;
        end
    end

    urp_frac_div u_div (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .ce_i    (ce_i),
        .m_i     (m_reg),
        .limit_i (lim_reg),
        .tick_o  (tick)
    );

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    urp_rx_st_t rx_st_next;
    logic [3:0] rx_cnt_reg;
    logic [3:0] rx_cnt_next;
    logic [2:0] rx_bit_reg;
    logic [2:0] rx_bit_next;
    logic [7:0] rx_sh_reg;
    logic [7:0] rx_sh_next;
    logic       rx_prev_reg;
    logic       rx_prev_next;
    logic       rx_vld_reg;
    logic       rx_vld_next;
    logic       ferr_reg;
    logic       ferr_next;

    // Edge found only at ticks, so start alignment is within one tick
    always_comb begin
        rx_st_next   = rx_st_reg;
        rx_cnt_next  = rx_cnt_reg;
        rx_bit_next  = rx_bit_reg;
        rx_sh_next   = rx_sh_reg;
        rx_prev_next = rx_prev_reg;
        rx_vld_next  = 1'b0;
        ferr_next    = 1'b0;
        if (tick) begin
            rx_prev_next = rx_s;
            rx_cnt_next  = rx_cnt_reg + 4'h1;
            case (rx_st_reg)
                R_IDLE: begin
                    rx_cnt_next = 4'h0;
                    if (rx_prev_reg && !rx_s) begin
                        rx_st_next = R_START; // [RQ4]
                    end
                end
                R_START: begin
                    if (rx_cnt_reg == TICK_MID) begin
                        rx_cnt_next = 4'h0;
                        rx_bit_next = 3'h0;
                        rx_st_next  = rx_s ? R_IDLE : R_DATA; // [RQ4]
                    end
                end
                R_DATA: begin
                    if (rx_cnt_reg == TICK_LAST) begin
                        rx_sh_next = {rx_s, rx_sh_reg[7:1]}; // [RQ3]
                        rx_bit_next = rx_bit_reg + 3'h1;
                        if (rx_bit_reg == BIT_LAST) begin
                            rx_st_next = R_STOP;
                        end
                    end
                end
                R_STOP: begin
                    if (rx_cnt_reg == TICK_LAST) begin
                        rx_vld_next = rx_s;  // [RQ3]
                        ferr_next   = !rx_s;
                        rx_st_next  = R_IDLE;
                    end
                end
                default: begin
                    rx_st_next = R_IDLE;
                end
            endcase
        end
        if (!mode_reg) begin
            rx_st_next = R_IDLE;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            rx_st_reg   <= R_IDLE;
            rx_cnt_reg  <= 4'h0;
            rx_bit_reg  <= 3'h0;
            rx_sh_reg   <= 8'h00;
            rx_prev_reg <= 1'b1;
            rx_vld_reg  <= 1'b0;
            ferr_reg    <= 1'b0;
        end else if (ce_i) begin
            rx_st_reg   <= rx_st_next;
            rx_cnt_reg  <= rx_cnt_next;
            rx_bit_reg  <= rx_bit_next;
            rx_sh_reg   <= rx_sh_next;
            rx_prev_reg <= rx_prev_next;
            rx_vld_reg  <= rx_vld_next;
            ferr_reg    <= ferr_next;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    urp_tx_st_t tx_st_next;
    logic [3:0] tx_cnt_reg;
    logic [3:0] tx_cnt_next;
    logic [2:0] tx_bit_reg;
    logic [2:0] tx_bit_next;
    logic [7:0] tx_sh_reg;
    logic [7:0] tx_sh_next;
    logic       tx_line_reg;
    logic       tx_line_next;
    logic       tx_go;
    logic [7:0] tx_byte;

    // Start bit begins on a system edge; its length may fall short of 16 ticks by up to one tick
    always_comb begin
        tx_st_next   = tx_st_reg;
        tx_cnt_next  = tx_cnt_reg;
        tx_bit_next  = tx_bit_reg;
        tx_sh_next   = tx_sh_reg;
        tx_line_next = tx_line_reg;
        case (tx_st_reg)
            T_IDLE: begin
                tx_line_next = 1'b1; // [RQ19]
                if (tx_go) begin
                    tx_sh_next   = tx_byte;
                    tx_cnt_next  = 4'h0;
                    tx_line_next = 1'b0;
                    tx_st_next   = T_START;
                end
            end
            T_START: begin
                if (tick) begin
                    tx_cnt_next = tx_cnt_reg + 4'h1;
                    if (tx_cnt_reg == TICK_LAST) begin
                        tx_bit_next  = 3'h0;
                        tx_line_next = tx_sh_reg[0]; // [RQ19]
                        tx_st_next   = T_DATA;
                    end
                end
            end
            T_DATA: begin
                if (tick) begin
                    tx_cnt_next = tx_cnt_reg + 4'h1;
                    if (tx_cnt_reg == TICK_LAST) begin
                        tx_sh_next   = {1'b0, tx_sh_reg[7:1]};
                        tx_bit_next  = tx_bit_reg + 3'h1;
                        tx_line_next = tx_sh_reg[1]; // [RQ19]
                        if (tx_bit_reg == BIT_LAST) begin
                            tx_line_next = 1'b1; // [RQ3]
                            tx_st_next   = T_STOP;
                        end
                    end
                end
            end
            T_STOP: begin
                if (tick) begin
                    tx_cnt_next = tx_cnt_reg + 4'h1;
                    if (tx_cnt_reg == TICK_LAST) begin
                        tx_st_next = T_IDLE;
                    end
                end
            end
            default: begin
                tx_st_next   = T_IDLE;
                tx_line_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            tx_st_reg   <= T_IDLE;
            tx_cnt_reg  <= 4'h0;
            tx_bit_reg  <= 3'h0;
            tx_sh_reg   <= 8'h00;
            tx_line_reg <= 1'b1;
        end else if (ce_i) begin
            tx_st_reg   <= tx_st_next;
            tx_cnt_reg  <= tx_cnt_next;
            tx_bit_reg  <= tx_bit_next;
            tx_sh_reg   <= tx_sh_next;
            tx_line_reg <= tx_line_next;
        end
    end

    // ------------------------------------------------------------------
    // Command protocol
    // ------------------------------------------------------------------
    urp_proto_st_t p_next;
    logic [7:0]    cmd_reg;
    logic [7:0]    cmd_next;
    logic [7:0]    addr_reg;
    logic [7:0]    addr_next;
    logic [7:0]    cnt_reg;
    logic [7:0]    cnt_next;
    logic [7:0]    wd_reg;
    logic [7:0]    wd_next;
    logic          we_next;
    logic          re_reg;
    logic          re_next;
    logic          tx_busy;

    assign tx_busy = (tx_st_reg != T_IDLE);

    // Address steps the cycle after a write strobe and after read data is captured, so each access sees the old one
    always_comb begin
        p_next    = p_reg;
        cmd_next  = cmd_reg;
        addr_next = addr_reg;
        cnt_next  = cnt_reg;
        wd_next   = wd_reg;
        we_next   = 1'b0;
        re_next   = 1'b0;
        tx_go     = 1'b0;
        tx_byte   = ACK_BYTE;
        if ((we_reg || p_reg == P_RDCAP) && !cmd_reg[CMD_HOLD_BIT]) begin
            addr_next = addr_reg + 8'h01; // [RQ9] [RQ13]
        end
        case (p_reg)
            P_ZERO: begin
                if (rx_vld_reg && rx_sh_reg == ZERO_BYTE) begin
                    p_next = P_CMD;
                end
            end
            P_CMD: begin
                if (rx_vld_reg) begin
                    cmd_next = rx_sh_reg;
                    p_next   = dbl_reg ? P_AHI : P_ALO; // [RQ17]
                end
            end
            P_AHI: begin
                if (rx_vld_reg) begin
                    p_next = P_ALO; // [RQ11]
                end
            end
            P_ALO: begin
                if (rx_vld_reg) begin
                    addr_next = rx_sh_reg; // [RQ11]
                    p_next    = P_LEN;
                end
            end
            P_LEN: begin
                if (rx_vld_reg) begin
                    cnt_next = rx_sh_reg;
                    if (rx_sh_reg == 8'h00) begin
                        p_next = finish_st(cmd_reg);
                    end else if (cmd_op(cmd_reg) == OP_READ) begin
                        p_next = P_RDREQ; // [RQ12]
                    end else if (cmd_op(cmd_reg) == OP_WRITE) begin
                        p_next = P_WDATA; // [RQ12]
                    end else begin
                        p_next = finish_st(cmd_reg); // [RQ18]
                    end
                end
            end
            P_WDATA: begin
                if (rx_vld_reg) begin
                    wd_next  = rx_sh_reg;
                    we_next  = 1'b1;
                    cnt_next = cnt_reg - 8'h01;
                    if (cnt_reg == 8'h01) begin
                        p_next = finish_st(cmd_reg);
                    end
                end
            end
            P_RDREQ: begin
                if (!tx_busy) begin
                    re_next = 1'b1;
                    p_next  = P_RDWT;
                end
            end
            P_RDWT: begin
                p_next = P_RDCAP;
            end
            P_RDCAP: begin
                tx_go    = 1'b1;
                tx_byte  = reg_rdata_i;
                cnt_next = cnt_reg - 8'h01;
                p_next   = (cnt_reg == 8'h01) ? finish_st(cmd_reg) : P_RDREQ; // [RQ15]
            end
            P_ACK: begin
                if (!tx_busy) begin
                    tx_go  = 1'b1; // [RQ14] [RQ15]
                    p_next = P_ZERO;
                end
            end
            default: begin
                p_next = P_ZERO;
            end
        endcase
        if (!mode_reg) begin
            p_next = P_ZERO;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            p_reg    <= P_ZERO;
            cmd_reg  <= 8'h00;
            addr_reg <= 8'h00;
            cnt_reg  <= 8'h00;
            wd_reg   <= 8'h00;
            we_reg   <= 1'b0;
            re_reg   <= 1'b0;
        end else if (ce_i) begin
            p_reg    <= p_next;
            cmd_reg  <= cmd_next;
            addr_reg <= addr_next;
            cnt_reg  <= cnt_next;
            wd_reg   <= wd_next;
            we_reg   <= we_next;
            re_reg   <= re_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign tx_o        = tx_line_reg;
    assign reg_addr_o  = addr_reg;
    assign reg_wdata_o = wd_reg;
    assign reg_we_o    = we_reg;
    assign reg_re_o    = re_reg;
    assign uart_mode_o = mode_reg;
    assign busy_o      = !idle;
    assign frame_err_o = ferr_reg;

endmodule

/* design/urp_pkg.sv */
// Purpose : Shared constants and state types for the serial register access port.
// Assumes : A 16x sample tick drives all bit timing.
// Notes   : Divider reset values give 9600 baud from a 77.76 MHz system clock.
package urp_pkg;

    // ------------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------------
    localparam logic [3:0] TICK_MID  = 4'h7;  // Ticks from start edge to start-bit centre
    localparam logic [3:0] TICK_LAST = 4'hf;  // Last tick of a 16-tick bit
    localparam logic [2:0] BIT_LAST  = 3'h7;  // Index of the eighth data bit
    localparam logic [1:0] STRAP_WAIT = 2'h3; // Cycles before strap sample is trusted

    // ------------------------------------------------------------------
    // Protocol bytes and command fields
    // ------------------------------------------------------------------
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    localparam logic [7:0] ACK_BYTE     = 8'h5a;
    localparam logic [1:0] OP_NOP       = 2'h0;
    localparam logic [1:0] OP_READ      = 2'h1;
    localparam logic [1:0] OP_WRITE     = 2'h2;
    localparam int         CMD_OP_LSB   = 4;  // Command code sits in bits 5:4
    localparam int         CMD_HOLD_BIT = 1;  // Set holds the address for the burst
    localparam int         CMD_ACK_BIT  = 0;  // Set asks for an acknowledge byte

    // ------------------------------------------------------------------
    // Mode selection and divider configuration
    // ------------------------------------------------------------------
    localparam logic [1:0]  MODE_UART   = 2'h2;
    localparam int          CFG_DBL_BIT = 8;      // Double-address bit in numerator word
    localparam logic [7:0]  M_RST       = 8'h04;  // Numerator after reset
    localparam logic [15:0] LIMIT_RST   = 16'h07e5; // N minus M after reset
    localparam logic        DBL_RST     = 1'b1;   // Two address bytes after reset
    localparam logic [2:0]  SYNC_RST    = 3'h1;   // Strap bits low, receive line idle high

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        R_IDLE  = 2'h0,
        R_START = 2'h1,
        R_DATA  = 2'h3,
        R_STOP  = 2'h2
    } urp_rx_st_t;

    typedef enum logic [1:0] {
        T_IDLE  = 2'h0,
        T_START = 2'h1,
        T_DATA  = 2'h3,
        T_STOP  = 2'h2
    } urp_tx_st_t;

    typedef enum logic [3:0] {
        P_ZERO  = 4'h0,
        P_CMD   = 4'h1,
        P_AHI   = 4'h3,
        P_ALO   = 4'h2,
        P_LEN   = 4'h6,
        P_WDATA = 4'h7,
        P_RDREQ = 4'h5,
        P_RDWT  = 4'h4,
        P_RDCAP = 4'hc,
        P_ACK   = 4'hd
    } urp_proto_st_t;

endpackage

/* design/urp_frac_div.sv */
// Purpose : Fractional M/N divider producing a one-cycle sample tick.
// Assumes : Limit holds N minus M and is larger than zero.
// Notes   : Tick rate is clock rate times M over N, with jitter of one cycle.
`timescale 1ns/1ps
module urp_frac_div
    import urp_pkg::*;
(
    input  wire logic        clock_i,  // System clock
    input  wire logic        rstn_i,   // Synchronous reset, active low
    input  wire logic        ce_i,     // Clock enable
    input  wire logic [7:0]  m_i,      // Numerator M
    input  wire logic [15:0] limit_i,  // N minus M
    output logic             tick_o    // Sample tick, one cycle wide
);

    logic [16:0] acc_reg;
    logic [16:0] acc_next;
    logic        tick_next;

    // ------------------------------------------------------------------
    // Accumulator: add M each cycle, drop N whenever it wraps
    // ------------------------------------------------------------------
    always_comb begin
        tick_next = 1'b0;
        if (acc_reg >= {1'b0, limit_i}) begin
            // acc + M - N equals acc - limit, so no wider sum is needed
            acc_next  = acc_reg - {1'b0, limit_i}; // [RQ5]
            tick_next = 1'b1;
        end else begin
            acc_next = acc_reg + {9'h000, m_i};
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            acc_reg <= 17'h00000;
            tick_o  <= 1'b0;
        end else if (ce_i) begin
            acc_reg <= acc_next;
            tick_o  <= tick_next;
        end
    end

endmodule

/* testbench/urp_host_model.sv */
// Purpose: Host controller model on the serial pins
// Assumes: BITC clock cycles per bit
// Notes: Receive line idles high between characters
`timescale 1ns/1ps
module urp_host_model #(parameter int BITC = 32) (
    input  wire logic clock_i, // Clock
    input  wire logic tx_i,    // Device transmit
    output logic      rx_o     // Device receive
);
    logic [7:0] q[$]; // Characters heard
    initial rx_o = 1'b1;
    // Send 8N1, LSB first, full stop bit
    task automatic put(input logic [7:0] b, input logic stp = 1'b1);
        for (int i = 0; i < 10 * BITC; i++) begin
            @(posedge clock_i);
            rx_o <= (i < BITC) ? 1'b0 : (i < 9 * BITC) ? b[i / BITC - 1]
                  : (stp || i % BITC > 24); // A bad stop is low from its start until well past its centre
        end
    endtask
    // Listen at bit centres from each start edge
    initial forever begin
        logic [7:0] b;
        @(negedge tx_i);
        repeat (BITC / 2) @(posedge clock_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge clock_i);
            b[i] = tx_i;
        end
        repeat (BITC) @(posedge clock_i);
        q.push_back(b);
    end
endmodule

/* testbench/urp_top_monitor.sv */
// Purpose: Port checks on urp_top
// Assumes: One clock domain
// Notes: Bound after the module
`timescale 1ns/1ps
module urp_top_monitor (
    input wire logic       clock_i,     // Clock
    input wire logic       rstn_i,      // Reset
    input wire logic       tx_o,        // Tx pin
    input wire logic [7:0] reg_addr_o,  // Address
    input wire logic       reg_we_o,    // Write
    input wire logic       reg_re_o,    // Read
    input wire logic       uart_mode_o, // Mode
    input wire logic       busy_o       // Busy
);
    // ----
    // Checks
    // ----
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);
    property p_we; reg_we_o |=> !reg_we_o; endproperty
    a_we: assert property (p_we) else $error("we");
    property p_excl; !(reg_we_o && reg_re_o); endproperty
    a_excl: assert property (p_excl) else $error("excl");
    property p_mode; reg_we_o |-> uart_mode_o && busy_o; endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_idle; !busy_o |-> tx_o; endproperty
    a_idle: assert property (p_idle) else $error("idle");
    // After a write strobe, address holds or steps by one only
    property p_step; reg_we_o |=> reg_addr_o - $past(reg_addr_o) <= 8'h01; endproperty
    a_step: assert property (p_step) else $error("step");
    property p_start; $fell(tx_o) |-> !tx_o [*8]; endproperty
    a_start: assert property (p_start) else $error("start");
    property p_gap; reg_re_o |=> !reg_re_o [*8]; endproperty
    a_gap: assert property (p_gap) else $error("gap");
    property p_rd; reg_re_o |-> ##2 !tx_o; endproperty
    a_rd: assert property (p_rd) else $error("rd");
    c_we: cover property (reg_we_o);
    c_re: cover property (reg_re_o);
    c_tx: cover property ($fell(tx_o));
endmodule
bind urp_top urp_top_monitor u_mon (.*);

/* testbench/tb_uart_register_access_port.sv */
// Purpose: Bench for the serial register port
// Assumes: M=1, limit=1 gives 32 cycles a bit
// Notes: An array answers the strobes
`timescale 1ns/1ps
module tb_uart_register_access_port;
    logic        clock_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, eep_sel_wr_i = 1'b0, rx_i;
    logic [1:0]  mode_strap_i = 2'h2, eep_sel_i = 2'h0;
    logic [15:0] baud_freq_i = 16'h0101, baud_limit_i = 16'h0001;
    logic        tx_o, reg_we_o, reg_re_o, uart_mode_o, busy_o, frame_err_o;
    logic [7:0]  reg_addr_o, reg_wdata_o, reg_rdata_i, mem[256];
    int          miscompares = 0, n_compared = 0, n_ferr = 0;
    urp_top dut (.*);
    urp_host_model host (.clock_i, .tx_i(tx_o), .rx_o(rx_i));
    // Clock, and register array read without delay
    always #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) if (reg_we_o) mem[reg_addr_o] <= reg_wdata_o;
    always @(posedge clock_i) if (frame_err_o === 1'b1) n_ferr++;
    assign reg_rdata_i = mem[reg_addr_o];
    task automatic chk(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] s[$]);
        foreach (s[i]) host.put(s[i]);
    endtask
    // Bounded wait, so a silent device cannot hang here
    task automatic rx_chk(input logic [7:0] exp);
        int n = 0;
        while (host.q.size() == 0 && n < 4000) begin
            @(posedge clock_i);
            n++;
        end
        chk(host.q.size() > 0 ? host.q.pop_front() : 8'hxx, exp);
    endtask
    task automatic t_mode(input logic [1:0] v, input logic [7:0] exp);
        @(posedge clock_i);
        eep_sel_wr_i <= 1'b1;
        eep_sel_i <= v;
        @(posedge clock_i);
        eep_sel_wr_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1 chk(8'(uart_mode_o), exp);
    endtask
    task automatic t_write();
        send({8'h00, 8'h21, 8'h00, 8'h10, 8'h02, 8'ha5, 8'h3c});
        rx_chk(8'h5a);
        chk(mem[8'h10], 8'ha5);
        chk(mem[8'h11], 8'h3c);
        $display("write done");
    endtask
    task automatic t_read();
        send({8'h00, 8'h13, 8'h00, 8'h10, 8'h02});
        rx_chk(8'ha5);
        rx_chk(8'ha5);
        rx_chk(8'h5a);
        $display("read done");
    endtask
    task automatic t_nop();
        send({8'h00, 8'hfd, 8'h00, 8'h10, 8'h01});
        rx_chk(8'h5a);
        send({8'h00, 8'h01, 8'h00, 8'h10, 8'h01});
        rx_chk(8'h5a);
        send({8'h00, 8'h20, 8'h00, 8'h12, 8'h01, 8'h66});
        repeat (400) @(posedge clock_i);
        chk(8'(host.q.size()), 8'h00);
        chk(mem[8'h12], 8'h66);
        $display("nop done");
    endtask
    task automatic t_single();
        baud_freq_i <= 16'h0001;
        send({8'h00, 8'h10, 8'h11, 8'h01});
        rx_chk(8'h3c);
        $display("single done");
    endtask
    task automatic t_ferr();
        host.put(8'h00, 1'b0);
        chk(8'(n_ferr), 8'h01);
        $display("ferr done");
    endtask
    task automatic finish_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        #1 chk(8'(uart_mode_o), 8'h01);
        t_mode(2'h1, 8'h00);
        t_mode(2'h2, 8'h01);
        t_write();
        t_read();
        t_nop();
        t_single();
        t_ferr();
        finish_test();
    end
    // Watchdog, about three times the expected run
    initial begin
        repeat (40000) @(posedge clock_i);
        miscompares++;
        finish_test();
    end
endmodule
